// *** src/seau_chk.sv ***
// Purpose: judges one request before it is issued to the core
// Assumes: request fields are stable while the top samples err
// Notes:   purely combinational; first failing test wins
`timescale 1ns/1ps
`default_nettype none
`include "seau_consts.svh"
module seau_chk
  import seau_pkg::*;
(
  seau_ctl_if.chk c
);

  // =====================================================================
  // legality tests
  always_comb begin
    c.err = ERR_NONE;
    case (c.op)
      OP_PUSH, OP_POP: begin
        if (c.reglist == 16'h0000) begin
          c.err = ERR_EMPTY;
        end else if (c.reglist[`SEAU_REG_SP]) begin
          c.err = ERR_SP_LIST;
        end else if (c.op == OP_PUSH && c.reglist[`SEAU_REG_PC]) begin
          c.err = ERR_PC_PUSH;
        end else if (c.op == OP_POP && c.reglist[`SEAU_REG_PC] && c.reglist[`SEAU_REG_LR]) begin
          c.err = ERR_PC_LR;
        end else if (c.op == OP_POP && c.reglist[`SEAU_REG_PC] && c.cond && !c.last) begin
          c.err = ERR_COND_POS;
        end
      end
      OP_LDX, OP_STX: begin
        if (c.base == `SEAU_REG_PC || c.xfer == `SEAU_REG_PC ||
            (c.op == OP_STX && c.stat == `SEAU_REG_PC)) begin
          c.err = ERR_PC_OPND;
        end else if (c.xfer == `SEAU_REG_SP || (c.op == OP_STX && c.stat == `SEAU_REG_SP)) begin
          c.err = ERR_SP_OPND;
        end else if (c.op == OP_STX && c.size == SZ_WORD &&
                     (c.stat == c.xfer || c.stat == c.base)) begin
          c.err = ERR_ALIAS;
        end else if (c.offset[1:0] != 2'h0 || c.offset > `SEAU_OFS_MAX ||
                     (c.size != SZ_WORD && c.offset != 10'h000)) begin
          c.err = ERR_OFFSET;
        end else if (c.op == OP_STX && c.resv_vld && c.addr != c.resv_addr) begin
          c.err = ERR_ADDR;
        end else if (c.op == OP_STX && c.resv_vld && c.size != c.resv_size) begin
          c.err = ERR_SIZE;
        end
      end
      OP_CLRX: begin
        c.err = ERR_NONE;
      end
      default: begin
        c.err = ERR_BAD_OP;
      end
    endcase
  end

endmodule // seau_chk
`default_nettype wire

// *** src/seau_consts.svh ***
// Purpose: timing, register-number and field constants of the stack/exclusive issue controller
// Assumes: included by bare name before the module header and its package import
// Notes:   definitions only
`ifndef SEAU_CONSTS_SVH
`define SEAU_CONSTS_SVH

// =====================================================================
// register numbers of the core register file
`define SEAU_REG_SP      4'hd
`define SEAU_REG_LR      4'he
`define SEAU_REG_PC      4'hf

// =====================================================================
// exclusive offsets and status values
`define SEAU_OFS_MAX     10'h3fc
`define SEAU_STS_OK      1'h0
`define SEAU_STS_FAIL    1'h1

// =====================================================================
// loaded program counter: bit that must be set, and the default gap limit
`define SEAU_PC_MODE_BIT 0
`define SEAU_MAX_GAP     16
`define SEAU_GAP_SAT     8'hff

`endif

// *** src/seau_ctl_if.sv ***
// Purpose: links the top with its legality checker and reservation tracker
// Assumes: one clock domain
// Notes:   no clocking block
`timescale 1ns/1ps
`default_nettype none
interface seau_ctl_if;
  import seau_pkg::*;

  seau_op_t    op;
  logic [15:0] reglist;
  logic [3:0]  base;
  logic [3:0]  xfer;
  logic [3:0]  stat;
  logic [9:0]  offset;
  seau_size_t  size;
  logic        cond;
  logic        last;
  logic [31:0] addr;
  seau_err_t   err;
  logic        set;
  logic        clr;
  logic        tick;
  logic [31:0] rec_addr;
  seau_size_t  rec_size;
  logic        resv_vld;
  logic [31:0] resv_addr;
  seau_size_t  resv_size;
  logic        gap_over;

  modport chk (input op, reglist, base, xfer, stat, offset, size, cond, last, addr,
               resv_vld, resv_addr, resv_size, output err);
  modport resv (input set, clr, tick, rec_addr, rec_size,
                output resv_vld, resv_addr, resv_size, gap_over);
  modport top (output op, reglist, base, xfer, stat, offset, size, cond, last, addr,
               set, clr, tick, rec_addr, rec_size,
               input err, resv_vld, resv_addr, resv_size, gap_over);
endinterface
`default_nettype wire

// *** src/seau_host.sv ***
// Purpose: issues stack and exclusive instructions to the core, refusing illegal forms
// Assumes: core pins are asynchronous to ref_clk_in; core holds accept and done until seen
// Notes:   one instruction in flight; status and loaded pc ride with done through the same syncs
`timescale 1ns/1ps
`default_nettype none
`include "seau_consts.svh"
module seau_host
  import seau_pkg::*;
#(
  parameter int MAX_GAP = `SEAU_MAX_GAP
)(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // requester side
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire seau_op_t    req_op_in,
  input  wire logic [15:0] req_reglist_in,
  input  wire logic [3:0]  req_base_in,
  input  wire logic [3:0]  req_xfer_in,
  input  wire logic [3:0]  req_stat_in,
  input  wire logic [9:0]  req_offset_in,
  input  wire seau_size_t  req_size_in,
  input  wire logic        req_cond_in,
  input  wire logic        req_last_in,
  input  wire logic [31:0] req_addr_in,
  output logic             done_out,
  output seau_err_t        err_code_out,
  output logic             store_exclusive_word_status_out,
  output logic             branch_vld_out,
  output logic [31:0]      branch_target_out,
  output logic             gap_warn_out,
  // core side
  output logic             instr_valid_out,
  output seau_op_t         instr_op_out,
  output logic [15:0]      instr_reglist_out,
  output logic [3:0]       instr_base_out,
  output logic [3:0]       instr_xfer_out,
  output logic [3:0]       instr_stat_out,
  output logic [9:0]       instr_offset_out,
  output seau_size_t       instr_size_out,
  output logic             instr_cond_out,
  input  wire logic        core_accept_in,
  input  wire logic        core_done_in,
  input  wire logic        core_status_in,
  input  wire logic [31:0] core_pc_value_in
);

  // =====================================================================
  // state
  typedef struct packed {
    seau_state_t st;
    seau_op_t    op;
    logic [15:0] reglist;
    logic [3:0]  base;
    logic [3:0]  xfer;
    logic [3:0]  stat;
    logic [9:0]  offset;
    seau_size_t  size;
    logic        cond;
    logic        last;
    logic [31:0] addr;
    logic        done;
    seau_err_t   err;
    logic        status;
    logic        br_vld;
    logic [31:0] br_tgt;
    logic        gap_warn;
    logic        acc_m;
    logic        acc_s;
    logic        fin_m;
    logic        fin_s;
    logic        sts_m;
    logic        sts_s;
    logic [31:0] pcv_m;
    logic [31:0] pcv_s;
  } seau_host_st_t;

  seau_host_st_t q_ff;
  seau_host_st_t nxt_q;
  seau_ctl_if    ctl ();

  // =====================================================================
  // helpers
  seau_chk u_chk (
    .c (ctl.chk)
  );

  seau_resv #(
    .MAX_GAP (MAX_GAP)
  ) u_resv (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .r          (ctl.resv)
  );

  assign ctl.op       = req_op_in;
  assign ctl.reglist  = req_reglist_in;
  assign ctl.base     = req_base_in;
  assign ctl.xfer     = req_xfer_in;
  assign ctl.stat     = req_stat_in;
  assign ctl.offset   = req_offset_in;
  assign ctl.size     = req_size_in;
  assign ctl.cond     = req_cond_in;
  assign ctl.last     = req_last_in;
  assign ctl.addr     = req_addr_in;
  assign ctl.rec_addr = q_ff.addr;
  assign ctl.rec_size = q_ff.size;

  // =====================================================================
  // sequencer
  always_comb begin
    nxt_q = q_ff;
    nxt_q.done  = 1'b0;
    ctl.set  = 1'b0;
    ctl.clr  = 1'b0;
    ctl.tick = 1'b0;
    // pins are asynchronous: two flops before any use
    nxt_q.acc_m = core_accept_in;
    nxt_q.acc_s = q_ff.acc_m;
    nxt_q.fin_m = core_done_in;
    nxt_q.fin_s = q_ff.fin_m;
    nxt_q.sts_m = core_status_in;
    nxt_q.sts_s = q_ff.sts_m;
    nxt_q.pcv_m = core_pc_value_in;
    nxt_q.pcv_s = q_ff.pcv_m;
    case (q_ff.st)
      S_IDLE: begin
        if (req_valid_in) begin
          nxt_q.op       = req_op_in;
          nxt_q.reglist  = req_reglist_in;
          nxt_q.base     = req_base_in;
          nxt_q.xfer     = req_xfer_in;
          nxt_q.stat     = req_stat_in;
          nxt_q.offset   = req_offset_in;
          nxt_q.size     = req_size_in;
          nxt_q.cond     = req_cond_in;
          nxt_q.last     = req_last_in;
          nxt_q.addr     = req_addr_in;
          nxt_q.br_vld   = 1'b0;
          nxt_q.status   = `SEAU_STS_OK;
          nxt_q.err      = ctl.err;
          nxt_q.gap_warn = (req_op_in == OP_STX) && ctl.gap_over;
          if (ctl.err != ERR_NONE) begin
            // refused: nothing reaches the core
            nxt_q.done = 1'b1;
            nxt_q.st   = S_REPORT;
          end else begin
            nxt_q.st = S_ISSUE;
          end
        end
      end
      S_ISSUE: begin
        if (q_ff.acc_s) begin
          nxt_q.st = S_WAIT;
        end
      end
      S_WAIT: begin
        if (q_ff.fin_s) begin
          nxt_q.st   = S_REPORT;
          nxt_q.done = 1'b1;
          case (q_ff.op)
            OP_LDX: begin
              ctl.set = 1'b1;
            end
            OP_STX: begin
              ctl.clr       = 1'b1;
              nxt_q.status  = q_ff.sts_s;
              // a cleared reservation can only end in failure
              if (!ctl.resv_vld && q_ff.sts_s == `SEAU_STS_OK) begin
                nxt_q.err = ERR_STS;
              end
            end
            OP_CLRX: begin
              ctl.clr = 1'b1;
            end
            OP_POP: begin
              ctl.tick = 1'b1;
              if (q_ff.reglist[`SEAU_REG_PC]) begin
                if (!q_ff.pcv_s[`SEAU_PC_MODE_BIT]) begin
                  nxt_q.err = ERR_PC_BIT0;
                end else begin
                  nxt_q.br_vld = 1'b1;
                  nxt_q.br_tgt = {q_ff.pcv_s[31:1], 1'b0};
                end
              end
            end
            default: begin
              ctl.tick = 1'b1;
            end
          endcase
        end
      end
      S_REPORT: begin
        nxt_q.st = S_IDLE;
      end
      default: begin
        nxt_q.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // =====================================================================
  // outputs
  assign req_ready_out     = (q_ff.st == S_IDLE);
  assign instr_valid_out   = (q_ff.st == S_ISSUE);
  assign instr_op_out      = q_ff.op;
  assign instr_reglist_out = q_ff.reglist;
  assign instr_base_out    = q_ff.base;
  assign instr_xfer_out    = q_ff.xfer;
  assign instr_stat_out    = q_ff.stat;
  assign instr_offset_out  = q_ff.offset;
  assign instr_size_out    = q_ff.size;
  assign instr_cond_out    = q_ff.cond;
  assign done_out          = q_ff.done;
  assign err_code_out      = q_ff.err;
  assign store_exclusive_word_status_out  = q_ff.status;
  assign branch_vld_out    = q_ff.br_vld;
  assign branch_target_out = q_ff.br_tgt;
  assign gap_warn_out      = q_ff.gap_warn;

  // =====================================================================
  // checks
  a_list_no_sp:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    instr_valid_out && !seau_is_excl(instr_op_out) && instr_op_out != OP_CLRX
    |-> !instr_reglist_out[`SEAU_REG_SP])
    else $error("stack list holds stack pointer");
  a_push_no_pc:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    instr_valid_out && instr_op_out == OP_PUSH |-> !instr_reglist_out[`SEAU_REG_PC])
    else $error("push list holds program counter");
  a_pop_pc_lr:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    instr_valid_out && instr_op_out == OP_POP && instr_reglist_out[`SEAU_REG_PC]
    |-> !instr_reglist_out[`SEAU_REG_LR])
    else $error("pop lists both pc and link register");
  a_cond_pop_last:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    instr_valid_out && instr_op_out == OP_POP && instr_reglist_out[`SEAU_REG_PC] && instr_cond_out
    |-> q_ff.last)
    else $error("conditional pc pop not last in block");
  a_excl_no_pc:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    instr_valid_out && seau_is_excl(instr_op_out)
    |-> instr_base_out != `SEAU_REG_PC && instr_xfer_out != `SEAU_REG_PC && instr_xfer_out != `SEAU_REG_SP)
    else $error("exclusive operand uses pc or sp");
  a_store_exclusive_word_alias:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    instr_valid_out && instr_op_out == OP_STX && instr_size_out == SZ_WORD
    |-> instr_stat_out != instr_xfer_out && instr_stat_out != instr_base_out)
    else $error("store status register aliases an operand");
  a_offset_range:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    instr_valid_out && seau_is_excl(instr_op_out)
    |-> instr_offset_out[1:0] == 2'h0 && instr_offset_out <= `SEAU_OFS_MAX)
    else $error("exclusive offset out of range");
  a_pair_addr:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    instr_valid_out && instr_op_out == OP_STX && ctl.resv_vld
    |-> q_ff.addr == ctl.resv_addr && instr_size_out == ctl.resv_size)
    else $error("store exclusive does not match reservation");
  a_pc_bit0:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    q_ff.st == S_WAIT && q_ff.fin_s && q_ff.op == OP_POP && q_ff.reglist[`SEAU_REG_PC]
    |=> done_out && (branch_vld_out == q_ff.pcv_s[0]) && !branch_target_out[0])
    else $error("loaded pc not judged");
  a_refused_report:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    req_ready_out && req_valid_in && ctl.err != ERR_NONE
    |=> done_out && !instr_valid_out ##1 req_ready_out)
    else $error("refused request not reported");

endmodule // seau_host
`default_nettype wire

// *** src/seau_pkg.sv ***
// Purpose: shared types of the stack/exclusive issue controller
// Assumes: nothing
// Notes:   constants live in seau_consts.svh
package seau_pkg;

  // =====================================================================
  // operations and sizes
  typedef enum logic [2:0] {
    OP_PUSH = 3'h0,
    OP_POP  = 3'h1,
    OP_LDX  = 3'h2,
    OP_STX  = 3'h3,
    OP_CLRX = 3'h4
  } seau_op_t;

  typedef enum logic [1:0] {
    SZ_WORD = 2'h0,
    SZ_HALF = 2'h1,
    SZ_BYTE = 2'h2
  } seau_size_t;

  // =====================================================================
  // verdicts reported to the requester
  typedef enum logic [3:0] {
    ERR_NONE     = 4'h0,
    ERR_EMPTY    = 4'h1,
    ERR_SP_LIST  = 4'h2,
    ERR_PC_PUSH  = 4'h3,
    ERR_PC_LR    = 4'h4,
    ERR_COND_POS = 4'h5,
    ERR_PC_OPND  = 4'h6,
    ERR_SP_OPND  = 4'h7,
    ERR_ALIAS    = 4'h8,
    ERR_OFFSET   = 4'h9,
    ERR_ADDR     = 4'ha,
    ERR_SIZE     = 4'hb,
    ERR_PC_BIT0  = 4'hc,
    ERR_STS      = 4'hd,
    ERR_BAD_OP   = 4'he
  } seau_err_t;

  // gray along idle -> issue -> wait -> report
  typedef enum logic [1:0] {
    S_IDLE   = 2'h0,
    S_ISSUE  = 2'h1,
    S_WAIT   = 2'h3,
    S_REPORT = 2'h2
  } seau_state_t;

  function automatic logic seau_is_excl(input seau_op_t op);
    return (op == OP_LDX) || (op == OP_STX);
  endfunction

endpackage

// *** src/seau_resv.sv ***
// Purpose: host copy of the core's exclusive reservation and the gap since it
// Assumes: set and clr never arrive together
// Notes:   gap counter saturates so a stale reservation keeps warning
`timescale 1ns/1ps
`default_nettype none
`include "seau_consts.svh"
module seau_resv
  import seau_pkg::*;
#(
  parameter int MAX_GAP = `SEAU_MAX_GAP
)(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  seau_ctl_if.resv r
);

  if (MAX_GAP < 1 || MAX_GAP > 254) begin : g_bad_gap
    $error("seau_resv: MAX_GAP must lie in 1..254");
  end

  typedef struct packed {
    logic        vld;
    logic [31:0] addr;
    seau_size_t  size;
    logic [7:0]  gap;
  } seau_resv_st_t;

  seau_resv_st_t q_ff;
  seau_resv_st_t nxt_q;

  // =====================================================================
  // reservation update
  always_comb begin
    nxt_q = q_ff;
    if (r.tick && q_ff.vld && q_ff.gap != `SEAU_GAP_SAT) begin
      nxt_q.gap = q_ff.gap + 8'h01;
    end
    if (r.clr) begin
      nxt_q.vld = 1'b0;
    end
    if (r.set) begin
      nxt_q.vld  = 1'b1;
      nxt_q.addr = r.rec_addr;
      nxt_q.size = r.rec_size;
      nxt_q.gap  = 8'h00;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign r.resv_vld  = q_ff.vld;
  assign r.resv_addr = q_ff.addr;
  assign r.resv_size = q_ff.size;
  assign r.gap_over  = q_ff.vld && (q_ff.gap > 8'(MAX_GAP));

  // =====================================================================
  // checks
  a_clear_drops_resv:
  assert property (@(posedge ref_clk_in) disable iff (rst_in) r.clr && !r.set |=> !r.resv_vld)
    else $error("reservation survived a clear");
  a_set_records_addr:
  assert property (@(posedge ref_clk_in) disable iff (rst_in)
    r.set |=> r.resv_vld && r.resv_addr == $past(r.rec_addr) && r.resv_size == $past(r.rec_size))
    else $error("reservation not recorded");

endmodule // seau_resv
`default_nettype wire

// *** verification/seau_core_model.sv ***
// Purpose: behavioural core that takes issued instructions and answers with status and pc value
// Assumes: one instruction in flight; host holds instr_valid until accept is seen
// Notes:   slow_in stretches both answers; lie_in reports store success whatever the monitor says
`timescale 1ns/1ps
`default_nettype none
module seau_core_model
  import seau_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        instr_valid_in,
  input  wire seau_op_t    instr_op_in,
  input  wire logic        slow_in,
  input  wire logic        lie_in,
  input  wire logic        foreign_in,
  input  wire logic [31:0] pc_in,
  output logic             accept_out,
  output logic             done_out,
  output logic             status_out,
  output logic [31:0]      pc_out,
  output logic [15:0]      exec_cnt_out
);
  int   ph;
  int   cnt;
  logic resv;
  logic sts;
  // ==================================================================
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      ph = 0; cnt = 0; resv = 0; sts = 0; accept_out <= 0; done_out <= 0; exec_cnt_out <= 16'h0;
    end else begin
      if (foreign_in) resv = 0; // foreign access spoils the reservation
      cnt = cnt + 1;
      case (ph)
        0: if (instr_valid_in && cnt > (slow_in ? 5 : 0)) begin
          accept_out <= 1; ph = 1;
        end
        1: if (!instr_valid_in) begin
          accept_out <= 0; ph = 2; cnt = 0; exec_cnt_out <= exec_cnt_out + 16'h1;
          case (instr_op_in)
            OP_LDX:  resv = 1;
            OP_STX:  begin sts = lie_in ? 1'b0 : !resv; resv = 0; end
            OP_CLRX: resv = 0;
            default: sts = 0;
          endcase
        end
        2: if (cnt > (slow_in ? 6 : 1)) begin
          done_out <= 1; ph = 3; cnt = 0;
        end
        default: if (cnt > 4) begin
          done_out <= 0; ph = 0; cnt = 0;
        end
      endcase
    end
  end
  // answer lines show the inverted answer while done is low
  assign status_out = done_out ? sts : !sts;
  assign pc_out     = done_out ? pc_in : ~pc_in;
endmodule // seau_core_model
`default_nettype wire

// *** verification/stack_exclusive_access_unit_tb.sv ***
// Purpose: self-checking bench of the stack/exclusive issue controller
// Assumes: inputs driven at the falling edge
// Notes:   MAX_GAP is shrunk to 1 so the gap warning is reached quickly
`timescale 1ns/1ps
`default_nettype none
module stack_exclusive_access_unit_tb;
  import seau_pkg::*;
  logic ref_clk_in = 0, rst_in = 1, req_valid = 0, req_cond = 0, req_last = 0;
  logic slow = 0, lie = 0, foreign = 0;
  seau_op_t req_op = OP_PUSH;
  seau_size_t req_size = SZ_WORD;
  logic [15:0] req_list = 16'h0, exec_cnt, instr_list;
  logic [3:0] req_base = 4'h0, req_xfer = 4'h0, req_stat = 4'h0;
  logic [9:0] req_ofs = 10'h0, instr_ofs;
  logic [31:0] req_addr = 32'h0, pc_val = 32'h0, core_pc, branch_target;
  logic req_ready, done, store_exclusive_word_status, branch_vld, gap_warn, instr_valid, core_accept, core_done, core_status;
  seau_err_t err_code;
  seau_op_t instr_op;
  seau_size_t instr_size;
  int num_errors = 0, comparisons = 0, cycles = 0;
  always #4 ref_clk_in = ~ref_clk_in;
  seau_host #(.MAX_GAP(1)) u_seau_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_valid_in(req_valid),
    .req_ready_out(req_ready), .req_op_in(req_op), .req_reglist_in(req_list), .req_base_in(req_base),
    .req_xfer_in(req_xfer), .req_stat_in(req_stat), .req_offset_in(req_ofs), .req_size_in(req_size),
    .req_cond_in(req_cond), .req_last_in(req_last), .req_addr_in(req_addr), .done_out(done),
    .err_code_out(err_code), .store_exclusive_word_status_out(store_exclusive_word_status), .branch_vld_out(branch_vld),
    .branch_target_out(branch_target), .gap_warn_out(gap_warn), .instr_valid_out(instr_valid),
    .instr_op_out(instr_op), .instr_reglist_out(instr_list), .instr_base_out(), .instr_xfer_out(),
    .instr_stat_out(), .instr_offset_out(instr_ofs), .instr_size_out(instr_size), .instr_cond_out(),
    .core_accept_in(core_accept),
    .core_done_in(core_done), .core_status_in(core_status), .core_pc_value_in(core_pc));
  seau_core_model u_seau_core_model (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid),
    .instr_op_in(instr_op), .slow_in(slow), .lie_in(lie), .foreign_in(foreign), .pc_in(pc_val),
    .accept_out(core_accept), .done_out(core_done), .status_out(core_status), .pc_out(core_pc),
    .exec_cnt_out(exec_cnt));
  // ==================================================================
  // shared tasks
  task automatic close_out();
    $display("checks %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  // refused forms answer one cycle after being taken and never reach the core
  task automatic issue(input seau_op_t op, input logic [15:0] l, input logic [3:0] b, x, s, input logic [9:0] o,
      input seau_size_t z, input logic c, la, input logic [31:0] a, input seau_err_t e, input logic st);
    int n;
    logic [15:0] n0;
    logic q;
    n = 0;
    n0 = exec_cnt;
    q = (e != ERR_NONE) && (e != ERR_PC_BIT0) && (e != ERR_STS);
    @(negedge ref_clk_in);
    while (req_ready !== 1'b1 && n < 50) begin @(negedge ref_clk_in); n++; end
    req_op = op; req_list = l; req_base = b; req_xfer = x; req_stat = s; req_ofs = o;
    req_size = z; req_cond = c; req_last = la; req_addr = a; req_valid = 1;
    // done is a one-cycle pulse: look at every falling edge, starting right after the taking edge
    @(negedge ref_clk_in);
    req_valid = 0;
    n = 1;
    while (done !== 1'b1 && n < 80) begin
      @(negedge ref_clk_in);
      n++;
    end
    check(done, 1, "done");
    check(err_code, e, "verdict");
    check(store_exclusive_word_status, st, "store status");
    if (q) check(n, 1, "refusal latency");
    check(exec_cnt, q ? n0 : n0 + 16'h1, "core executions");
  endtask
  task automatic stk(input seau_op_t op, input logic [15:0] l, input logic c, la, input seau_err_t e);
    issue(op, l, `SEAU_REG_SP, 4'h0, 4'h0, 10'h0, SZ_WORD, c, la, 32'h0, e, 0);
  endtask
  task automatic ex(input seau_op_t op, input logic [3:0] b, x, s, input logic [9:0] o, input seau_size_t z,
      input logic [31:0] a, input seau_err_t e, input logic st);
    issue(op, 16'h0, b, x, s, o, z, 0, 0, a, e, st);
  endtask
  // ==================================================================
  // scenarios
  task automatic t_reset();
    check({req_ready, done, store_exclusive_word_status, branch_vld, gap_warn, instr_valid}, 32'h20, "reset outputs");
    check(err_code, ERR_NONE, "reset verdict");
    $display("test reset done");
  endtask
  task automatic t_push();
    stk(OP_PUSH, 16'h40f1, 0, 0, ERR_NONE);
    check(instr_list, 16'h40f1, "issued list");
    stk(OP_PUSH, 16'h0000, 0, 0, ERR_EMPTY);
    stk(OP_PUSH, 16'h2001, 0, 0, ERR_SP_LIST);
    stk(OP_PUSH, 16'h8001, 0, 0, ERR_PC_PUSH);
    stk(OP_POP, 16'h2002, 0, 0, ERR_SP_LIST);
    $display("test push done");
  endtask
  task automatic t_pop();
    slow = 1;
    pc_val = 32'h0000_1235;
    stk(OP_POP, 16'hc001, 0, 0, ERR_PC_LR);
    stk(OP_POP, 16'h8001, 1, 0, ERR_COND_POS);
    stk(OP_POP, 16'h8401, 1, 1, ERR_NONE);
    check(branch_vld, 1, "branch taken");
    check(branch_target, 32'h0000_1234, "branch target");
    pc_val = 32'h0000_2468;
    stk(OP_POP, 16'h8000, 0, 0, ERR_PC_BIT0);
    check(branch_vld, 0, "even pc no branch");
    slow = 0;
    $display("test pop done");
  endtask
  task automatic t_forms();
    ex(OP_LDX, 4'hf, 4'h2, 4'h0, 10'h0, SZ_WORD, 32'h100, ERR_PC_OPND, 0);
    ex(OP_STX, 4'h1, 4'h2, 4'hf, 10'h0, SZ_WORD, 32'h100, ERR_PC_OPND, 0);
    ex(OP_LDX, 4'h1, 4'hd, 4'h0, 10'h0, SZ_WORD, 32'h100, ERR_SP_OPND, 0);
    ex(OP_STX, 4'h1, 4'h2, 4'hd, 10'h0, SZ_WORD, 32'h100, ERR_SP_OPND, 0);
    ex(OP_STX, 4'h1, 4'h2, 4'h2, 10'h0, SZ_WORD, 32'h100, ERR_ALIAS, 0);
    ex(OP_STX, 4'h1, 4'h2, 4'h1, 10'h0, SZ_WORD, 32'h100, ERR_ALIAS, 0);
    ex(OP_LDX, 4'h1, 4'h2, 4'h0, 10'h3fd, SZ_WORD, 32'h100, ERR_OFFSET, 0);
    ex(OP_LDX, 4'h1, 4'h2, 4'h0, 10'h004, SZ_HALF, 32'h100, ERR_OFFSET, 0);
    ex(OP_LDX, 4'h1, 4'h2, 4'h0, 10'h3fc, SZ_WORD, 32'h100, ERR_NONE, 0);
    check(instr_ofs, 10'h3fc, "issued offset");
    issue(seau_op_t'(3'h7), 16'h0, 4'h1, 4'h2, 4'h3, 10'h0, SZ_WORD, 0, 0, 32'h0, ERR_BAD_OP, 0);
    $display("test forms done");
  endtask
  task automatic t_pair();
    ex(OP_STX, 4'h1, 4'h2, 4'h3, 10'h0, SZ_WORD, 32'h104, ERR_ADDR, 0);
    ex(OP_STX, 4'h1, 4'h2, 4'h3, 10'h0, SZ_HALF, 32'h100, ERR_SIZE, 0);
    ex(OP_STX, 4'h1, 4'h2, 4'h3, 10'h0, SZ_WORD, 32'h100, ERR_NONE, 0);
    check(gap_warn, 0, "short gap");
    ex(OP_STX, 4'h1, 4'h2, 4'h3, 10'h0, SZ_WORD, 32'h200, ERR_NONE, 1);
    $display("test pair done");
  endtask
  task automatic t_sizes();
    seau_size_t z[3] = '{SZ_WORD, SZ_HALF, SZ_BYTE};
    foreach (z[i]) begin
      ex(OP_LDX, 4'h4, 4'h5, 4'h0, 10'h0, z[i], 32'h300, ERR_NONE, 0);
      check(instr_size, z[i], "load size");
      ex(OP_STX, 4'h4, 4'h5, 4'h6, 10'h0, z[i], 32'h300, ERR_NONE, 0);
    end
    $display("test sizes done");
  endtask
  task automatic t_clear();
    ex(OP_LDX, 4'h1, 4'h2, 4'h0, 10'h0, SZ_WORD, 32'h100, ERR_NONE, 0);
    ex(OP_CLRX, 4'h0, 4'h0, 4'h0, 10'h0, SZ_WORD, 32'h0, ERR_NONE, 0);
    ex(OP_STX, 4'h1, 4'h2, 4'h3, 10'h0, SZ_BYTE, 32'h0, ERR_NONE, 1);
    ex(OP_CLRX, 4'h0, 4'h0, 4'h0, 10'h0, SZ_WORD, 32'h0, ERR_NONE, 0);
    lie = 1;
    ex(OP_STX, 4'h1, 4'h2, 4'h3, 10'h0, SZ_WORD, 32'h0, ERR_STS, 0);
    lie = 0;
    $display("test clear done");
  endtask
  task automatic t_foreign();
    ex(OP_LDX, 4'h1, 4'h2, 4'h0, 10'h0, SZ_WORD, 32'h100, ERR_NONE, 0);
    @(negedge ref_clk_in) foreign = 1;
    @(negedge ref_clk_in) foreign = 0;
    ex(OP_STX, 4'h1, 4'h2, 4'h3, 10'h0, SZ_WORD, 32'h100, ERR_NONE, 1);
    ex(OP_LDX, 4'h1, 4'h2, 4'h0, 10'h0, SZ_WORD, 32'h100, ERR_NONE, 0);
    stk(OP_PUSH, 16'h0003, 0, 0, ERR_NONE);
    stk(OP_POP, 16'h0003, 0, 0, ERR_NONE);
    ex(OP_STX, 4'h1, 4'h2, 4'h3, 10'h0, SZ_WORD, 32'h100, ERR_NONE, 0);
    check(gap_warn, 1, "long gap");
    $display("test foreign done");
  endtask
  // ==================================================================
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    repeat (8) @(negedge ref_clk_in);
    rst_in = 0;
    t_reset();
    t_push();
    t_pop();
    t_forms();
    t_pair();
    t_sizes();
    t_clear();
    t_foreign();
    close_out();
  end
endmodule // stack_exclusive_access_unit_tb
`default_nettype wire
